// >>> design/dma_channel_ctrl.sv
`timescale 1ns/1ps
`include "dma_params.svh"
// Operation
// [R1] Serve highest priority 0..3, zero highest
// [R2] Rotate among tied channels per operand
// [R3] Reset sets all priorities to zero
// [R4] Capture read data on transfer-complete strobe
// [R5] Ignore abort in write after done; code does so only on dev_to_mem channels
// [R6] Ignored abort: transition, normal flags, no error
// [R7] Error stops channel, flags, records code
// [R8] Keep only first error code
// [R9] Later error never overwrites pending code
// [R10] Unrecorded error still blocks channel start
// [R11] Relinquish-retry frees bus, retries operation
// [R12] Register access during relinquished write corrupts operand
// [R13] Host asserts relinquish-retry only on reads
// [R14] Host uses halt for register access
// [R15] Slow chip-select negation zeroes lower word
// [R16] Chip select drops pending bus request
// [R17] Start during limited-rate may drop request early
module dma_channel_ctrl #(
    parameter int NUM_CH = `DMA_NUM_CH,
    parameter int DATA_W = `DMA_DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NUM_CH-1:0] start,
    input wire logic [NUM_CH-1:0] ext_req,
    input wire logic [NUM_CH*`DMA_PRIO_W-1:0] prio_wr_data,
    input wire logic [NUM_CH-1:0] prio_wr,
    input wire logic [NUM_CH-1:0] err_clear,
    input wire logic [NUM_CH-1:0] err_event,
    input wire logic [NUM_CH*`DMA_ERR_W-1:0] err_code_in,
    input wire logic [NUM_CH-1:0] abort_mode,
    input wire logic [NUM_CH-1:0] dev_to_mem,
    input wire logic [NUM_CH-1:0] limited_rate,
    input wire logic peripheral_control_line_n,
    input wire logic transfer_complete_strobe_n,
    input wire logic done_n,
    input wire logic relinquish_retry_n,
    input wire logic chip_sel_n,
    input wire logic lower_data_strobe_n,
    input wire logic upper_data_strobe_n,
    input wire logic bus_grant_n,
    input wire logic long_access,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [DATA_W-1:0] host_wr_data,
    output logic bus_request_n,
    output logic bus_grant_acknowledge_n,
    output logic bus_ctrl_oe_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic [NUM_CH*`DMA_PRIO_W-1:0] channel_priority_reg,
    output logic [NUM_CH-1:0] active_reg,
    output logic [NUM_CH-1:0] err_flag_reg,
    output logic [NUM_CH-1:0] periph_ctrl_transition_flag,
    output logic [NUM_CH-1:0] normal_termination_flag,
    output logic [NUM_CH*`DMA_ERR_W-1:0] channel_error_reg,
    output logic [DATA_W-1:0] lower_word_reg
);
    initial begin
        if (DATA_W < 1) $error("DATA_W must be positive");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0] pins_s;
    dma_sync2 #(.WIDTH(8), .RESET_VAL(8'h0f)) u_sync ( // Active-low pins reset to idle
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({ext_req, peripheral_control_line_n, transfer_complete_strobe_n,
                   done_n, relinquish_retry_n}),
        .sync_out(pins_s)
    );
    logic [NUM_CH-1:0] req_s;
    logic abort_s, dtc_s, done_s, rr_s;
    assign req_s = pins_s[7:4];
    assign abort_s = !pins_s[3];
    assign dtc_s = !pins_s[2];
    assign done_s = !pins_s[1];
    assign rr_s = !pins_s[0];

    // Host strobes: chip select and data strobes share one synchroniser bank
    logic [2:0] hst_s;
    logic bg_s_n;
    dma_sync2 #(.WIDTH(4), .RESET_VAL(4'hf)) u_sync_host (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({chip_sel_n, lower_data_strobe_n, upper_data_strobe_n, bus_grant_n}),
        .sync_out({hst_s, bg_s_n})
    );
    logic cs_s, ds_s;
    assign cs_s = !hst_s[2];
    assign ds_s = !hst_s[1] || !hst_s[0];

    // ****************************************
    // Priority registers and arbitration
    // ****************************************
    logic [NUM_CH-1:0] pend;
    logic grant_valid, advance;
    logic [1:0] grant_ch;
    assign pend = req_s & active_reg & ~err_flag_reg;

    dma_arbiter #(.NUM_CH(NUM_CH)) u_arb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(pend),
        .prio(channel_priority_reg),
        .advance(advance),
        .grant_valid(grant_valid),
        .grant_ch(grant_ch)
    ); // R1 R2

    // ****************************************
    // Transfer engine
    // ****************************************
    dma_pkg::xfer_state_e state_reg, state_next;
    logic [1:0] cur_ch_reg;
    logic [DATA_W-1:0] hold_reg;
    logic done_seen_reg;
    logic retry_write_reg;
    logic cs_pending_reg;
    logic ds_prev_reg;
    logic [1:0] slow_cnt_reg;
    logic cur_abort_mode, cur_d2m, abort_hit, abort_ignored;

    assign cur_abort_mode = abort_mode[cur_ch_reg];
    assign cur_d2m = dev_to_mem[cur_ch_reg];
    assign abort_hit = abort_s && cur_abort_mode && (state_reg != dma_pkg::ST_IDLE);
    assign abort_ignored = abort_hit && state_reg == dma_pkg::ST_WRITE && cur_d2m && done_seen_reg; // R5
    assign advance = state_reg == dma_pkg::ST_WRITE && dtc_s && !rr_s;

    // Next state of the operand cycle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dma_pkg::ST_IDLE: begin
                if (grant_valid && !rr_s && !bg_s_n && !cs_s) begin
                    state_next = retry_write_reg ? dma_pkg::ST_WRITE : dma_pkg::ST_READ;
                end
            end
            dma_pkg::ST_READ: begin
                if (rr_s) begin
                    state_next = dma_pkg::ST_RELQ; // R11
                end else if (abort_hit) begin
                    state_next = dma_pkg::ST_IDLE;
                end else if (dtc_s) begin
                    state_next = dma_pkg::ST_WRITE;
                end
            end
            dma_pkg::ST_WRITE: begin
                if (rr_s) begin
                    state_next = dma_pkg::ST_RELQ; // R11
                end else if (abort_hit && !abort_ignored) begin
                    state_next = dma_pkg::ST_IDLE;
                end else if (dtc_s) begin
                    state_next = dma_pkg::ST_IDLE;
                end
            end
            dma_pkg::ST_RELQ: begin
                if (!rr_s) begin
                    state_next = dma_pkg::ST_IDLE; // R11
                end
            end
        endcase
    end

    // Engine registers; holding register shared with host data path
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= dma_pkg::ST_IDLE;
            cur_ch_reg <= 2'h0;
            hold_reg <= '0;
            done_seen_reg <= 1'b0;
            retry_write_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == dma_pkg::ST_IDLE && state_next != dma_pkg::ST_IDLE) begin
                cur_ch_reg <= grant_ch;
            end
            if (state_reg == dma_pkg::ST_READ && dtc_s) begin
                hold_reg <= data_in; // R4
                done_seen_reg <= done_s;
            end else if (state_reg == dma_pkg::ST_RELQ && cs_s) begin
                hold_reg <= host_wr_data; // R12
            end
            if (state_reg == dma_pkg::ST_WRITE && rr_s) begin
                retry_write_reg <= 1'b1;
            end else if (state_reg == dma_pkg::ST_WRITE && dtc_s) begin
                retry_write_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Bus request and ownership
    // ****************************************
    logic start_any, lr_active;
    assign start_any = |start;
    assign lr_active = |(active_reg & limited_rate);

    // Request drops on chip select; early drop when start meets limited-rate channel
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_request_n <= 1'b1;
            bus_grant_acknowledge_n <= 1'b1;
            bus_ctrl_oe_n <= 1'b1;
            data_oe_n <= 1'b1;
            data_out <= '0;
            cs_pending_reg <= 1'b0;
        end else begin
            cs_pending_reg <= cs_s;
            if (cs_s) begin
                bus_request_n <= 1'b1; // R16
            end else if (start_any && lr_active && bus_grant_acknowledge_n) begin
                bus_request_n <= 1'b1; // R17
            end else begin
                bus_request_n <= !(grant_valid && state_reg == dma_pkg::ST_IDLE && !rr_s);
            end
            bus_grant_acknowledge_n <= !(state_next == dma_pkg::ST_READ || state_next == dma_pkg::ST_WRITE);
            bus_ctrl_oe_n <= !(state_next == dma_pkg::ST_READ || state_next == dma_pkg::ST_WRITE); // R11
            data_oe_n <= state_next != dma_pkg::ST_WRITE;
            data_out <= (state_reg == dma_pkg::ST_READ && dtc_s) ? data_in : hold_reg;
        end
    end

    // ****************************************
    // Host long-word access timing
    // ****************************************
    // Count cycles from strobe release to chip-select release
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ds_prev_reg <= 1'b0;
            slow_cnt_reg <= 2'h0;
            lower_word_reg <= '0;
        end else begin
            ds_prev_reg <= ds_s;
            if (cs_s && ds_s) begin
                slow_cnt_reg <= 2'h0;
                if (long_access) begin
                    lower_word_reg <= host_wr_data;
                end
            end else if (cs_s && slow_cnt_reg != 2'h3) begin
                slow_cnt_reg <= slow_cnt_reg + 2'h1;
            end
            if (cs_s && !ds_s && long_access && slow_cnt_reg == 2'h1) begin
                lower_word_reg <= '0; // R15
            end
        end
    end

    // ****************************************
    // Per-channel priority, status and error
    // ****************************************
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic err_now, ending, ndt_now;
        assign ndt_now = advance && cur_ch_reg == 2'(c) && done_seen_reg;
        assign err_now = err_event[c] ||
            (abort_hit && !abort_ignored && cur_ch_reg == 2'(c)) ||
            (start[c] && (err_flag_reg[c] || active_reg[c])); // R10

        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                channel_priority_reg[c*`DMA_PRIO_W +: `DMA_PRIO_W] <= `DMA_PRIO_RESET; // R3
                active_reg[c] <= 1'b0;
                err_flag_reg[c] <= 1'b0;
                periph_ctrl_transition_flag[c] <= 1'b0;
                normal_termination_flag[c] <= 1'b0;
                channel_error_reg[c*`DMA_ERR_W +: `DMA_ERR_W] <= `DMA_ERR_NONE;
            end else begin
                if (prio_wr[c]) begin
                    channel_priority_reg[c*`DMA_PRIO_W +: `DMA_PRIO_W] <=
                        prio_wr_data[c*`DMA_PRIO_W +: `DMA_PRIO_W]; // R1
                end
                // Set wins over clear for every flag
                if (err_now) begin
                    active_reg[c] <= 1'b0; // R7
                    err_flag_reg[c] <= 1'b1; // R7
                    if (!err_flag_reg[c]) begin
                        channel_error_reg[c*`DMA_ERR_W +: `DMA_ERR_W] <= err_event[c] ?
                            err_code_in[c*`DMA_ERR_W +: `DMA_ERR_W] : `DMA_ERR_EXT_ABORT; // R8 R9
                    end
                end else if (err_clear[c]) begin
                    err_flag_reg[c] <= 1'b0;
                    channel_error_reg[c*`DMA_ERR_W +: `DMA_ERR_W] <= `DMA_ERR_NONE;
                    normal_termination_flag[c] <= 1'b0;
                    periph_ctrl_transition_flag[c] <= 1'b0;
                end else if (start[c]) begin
                    active_reg[c] <= 1'b1;
                end
                if (ndt_now) begin
                    active_reg[c] <= 1'b0;
                    normal_termination_flag[c] <= 1'b1; // R6
                end
                if (abort_ignored && cur_ch_reg == 2'(c)) begin
                    periph_ctrl_transition_flag[c] <= 1'b1; // R6
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_write_rr;
        state_reg == dma_pkg::ST_WRITE && rr_s;
    endsequence

    a_rr_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_write_rr |=> state_reg == dma_pkg::ST_RELQ ##1 bus_ctrl_oe_n) // R11
        else $error("bus not released on relinquish");
    a_cs_drops_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cs_s && !bus_request_n |=> bus_request_n) // R16
        else $error("bus request kept under chip select");
    a_dtc_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == dma_pkg::ST_READ && dtc_s && !rr_s |=> hold_reg == $past(data_in)) // R4
        else $error("read data not captured on strobe");
    a_first_err_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        err_flag_reg[0] && !err_clear[0] |=> $stable(channel_error_reg[`DMA_ERR_W-1:0])) // R8 R9
        else $error("pending error code overwritten");
    a_err_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        err_event[1] |=> err_flag_reg[1] && !active_reg[1]) // R7
        else $error("error did not stop channel");
    a_no_start_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start[2] && err_flag_reg[2] |=> !active_reg[2]) // R10
        else $error("channel started with error pending");
    a_abort_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        abort_ignored && cur_ch_reg == 2'h0 && !err_event[0] && !start[0]
        |=> periph_ctrl_transition_flag[0] && !$rose(err_flag_reg[0])) // R5 R6
        else $error("ignored abort flagged as error");
    a_grant_best: assert property (@(posedge sys_clk) disable iff (!rst_n)
        grant_valid && pend[0] && channel_priority_reg[1:0] == 2'h0 |-> grant_valid
        && channel_priority_reg[grant_ch*`DMA_PRIO_W +: `DMA_PRIO_W] == 2'h0) // R1
        else $error("lower priority granted");
    a_rotate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        advance && grant_valid && pend[1:0] == 2'h3 && channel_priority_reg == 8'h00
        |=> grant_ch != $past(grant_ch) || !grant_valid) // R2
        else $error("tied channels not rotated");
endmodule : dma_channel_ctrl

// >>> design/dma_params.svh
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH
// ****************************************
// Channel layout and reset values
// ****************************************
`define DMA_NUM_CH 4
`define DMA_PRIO_W 2
`define DMA_PRIO_RESET 2'h0
`define DMA_ERR_W 5
`define DMA_ERR_NONE 5'h00
`define DMA_ERR_EXT_ABORT 5'h10
`define DMA_DATA_W 16
`endif

// >>> design/dma_pkg.sv
package dma_pkg;
    // Transfer engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_RELQ = 4'b1000
    } xfer_state_e;
endpackage : dma_pkg

// >>> design/dma_sync2.sv
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser, one per bit
// ****************************************
module dma_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL; // Idle level of the pin, so no false edge follows reset
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : dma_sync2

// >>> design/dma_arbiter.sv
`timescale 1ns/1ps
`include "dma_params.svh"
// ****************************************
// Priority arbiter with round-robin tie break
// ****************************************
module dma_arbiter #(
    parameter int NUM_CH = `DMA_NUM_CH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NUM_CH-1:0] req,
    input wire logic [NUM_CH*`DMA_PRIO_W-1:0] prio,
    input wire logic advance,
    output logic grant_valid,
    output logic [1:0] grant_ch
);
    logic [1:0] last_reg;
    logic [NUM_CH-1:0] at_best;
    logic [`DMA_PRIO_W-1:0] best;
    logic [1:0] pick;
    logic found;

    initial begin
        if (NUM_CH != 4) $error("dma_arbiter serves exactly four channels");
    end

    // Best pending level, then first tied channel after the last one served
    always_comb begin
        best = 2'h3;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (req[i] && prio[i*`DMA_PRIO_W +: `DMA_PRIO_W] < best) begin
                best = prio[i*`DMA_PRIO_W +: `DMA_PRIO_W];
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            at_best[i] = req[i] && (prio[i*`DMA_PRIO_W +: `DMA_PRIO_W] == best);
        end
        pick = 2'h0;
        found = 1'b0;
        for (int k = 1; k <= NUM_CH; k++) begin
            if (!found && at_best[2'(last_reg + 2'(k))]) begin
                pick = 2'(last_reg + 2'(k));
                found = 1'b1;
            end
        end
    end

    assign grant_valid = found;
    assign grant_ch = pick;

    // Rotation point moves after each operand transfer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            last_reg <= 2'h3;
        end else if (advance && found) begin
            last_reg <= pick;
        end
    end
endmodule : dma_arbiter

// >>> bench/dma_far_side.sv
`timescale 1ns/1ps
// ****************************************
// Bus owner and peripheral on the far side
// ****************************************
module dma_far_side (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_request_n,
    input wire logic bus_grant_acknowledge_n,
    input wire logic data_oe_n,
    input wire logic hold_grant,
    input wire logic slow,
    input wire logic [15:0] rd_val,
    output logic bus_grant_n,
    output logic transfer_complete_strobe_n,
    output logic [15:0] data_in
);
    logic [1:0] phase_reg;
    logic [4:0] cnt_reg;
    logic [15:0] noise_reg;
    wire reading = !bus_grant_acknowledge_n && data_oe_n;
    wire same = phase_reg == {bus_grant_acknowledge_n, data_oe_n};
    // Read data held only while the read cycle lasts, so a late capture sees churn
    assign data_in = reading ? rd_val : noise_reg;
    // Grant follows request unless the owner keeps the bus; one strobe per cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_grant_n <= 1'b1;
            phase_reg <= 2'h3;
            cnt_reg <= 5'h00;
            transfer_complete_strobe_n <= 1'b1;
            noise_reg <= 16'h0f0f;
        end else begin
            bus_grant_n <= hold_grant || (bus_request_n && bus_grant_acknowledge_n);
            phase_reg <= {bus_grant_acknowledge_n, data_oe_n};
            cnt_reg <= !same ? 5'h00 : (cnt_reg == 5'h1f ? cnt_reg : cnt_reg + 5'h01);
            transfer_complete_strobe_n <= !(!bus_grant_acknowledge_n && same && cnt_reg == (slow ? 5'h0a : 5'h02));
            noise_reg <= noise_reg + 16'h1357;
        end
    end
endmodule : dma_far_side

// >>> bench/test_dma_channel_ctrl.sv
`timescale 1ns/1ps
module test_dma_channel_ctrl;
    logic sys_clk, rst_n, pcl_n, done_n, rr_n, cs_n, lds_n, uds_n, hold_grant, slow, long_access;
    logic [3:0] start, ext_req, prio_wr, err_clear, err_event, abort_mode, dev_to_mem, limited_rate;
    logic [7:0] prio_wr_data;
    logic [19:0] err_code_in;
    logic [15:0] host_wr_data, rd_val, data_in, data_out, lower_word_reg;
    logic bus_grant_n, strobe_n, bus_request_n, bus_grant_acknowledge_n, bus_ctrl_oe_n, data_oe_n;
    logic [7:0] channel_priority_reg;
    logic [3:0] active_reg, err_flag_reg, periph_ctrl_transition_flag, normal_termination_flag;
    logic [19:0] channel_error_reg;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // ****************************************
    // Design and far side
    // ****************************************
    dma_channel_ctrl uut (.sys_clk, .rst_n, .start, .ext_req, .prio_wr_data, .prio_wr, .err_clear,
        .err_event, .err_code_in, .abort_mode, .dev_to_mem, .limited_rate,
        .peripheral_control_line_n(pcl_n), .transfer_complete_strobe_n(strobe_n), .done_n,
        .relinquish_retry_n(rr_n), .chip_sel_n(cs_n), .lower_data_strobe_n(lds_n),
        .upper_data_strobe_n(uds_n), .bus_grant_n, .long_access, .data_in, .host_wr_data,
        .bus_request_n, .bus_grant_acknowledge_n, .bus_ctrl_oe_n, .data_out, .data_oe_n,
        .channel_priority_reg, .active_reg, .err_flag_reg, .periph_ctrl_transition_flag,
        .normal_termination_flag, .channel_error_reg, .lower_word_reg);
    dma_far_side far (.sys_clk, .rst_n, .bus_request_n, .bus_grant_acknowledge_n, .data_oe_n,
        .hold_grant, .slow, .rd_val, .bus_grant_n, .transfer_complete_strobe_n(strobe_n), .data_in);
    // ****************************************
    // Clock, hang guard, shared tasks
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Whole run needs a few hundred cycles; far more means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    // Bus phases: 0 read, 1 write, 2 idle, 3 released, 4 request low
    function automatic logic seen(input int w);
        case (w)
            0: return bus_grant_acknowledge_n === 1'b0 && data_oe_n === 1'b1;
            1: return data_oe_n === 1'b0;
            2: return bus_grant_acknowledge_n === 1'b1;
            3: return bus_ctrl_oe_n === 1'b1;
            default: return bus_request_n === 1'b0;
        endcase
    endfunction : seen
    task automatic wait_for(input int w);
        int i;
        i = 0;
        while (!seen(w) && i < 300) begin
            cyc(1);
            i++;
        end
        chk(seen(w), 1);
    endtask : wait_for
    task automatic start_ch(input logic [3:0] m);
        start = m;
        cyc(1);
        start = 4'h0;
    endtask : start_ch
    task automatic set_prio(input logic [7:0] p);
        prio_wr_data = p;
        prio_wr = 4'hf;
        cyc(1);
        prio_wr = 4'h0;
    endtask : set_prio
    // One clock only: a longer pulse would also abort the next channel on the bus
    task automatic pulse_abort();
        pcl_n = 1'b0;
        cyc(1);
        pcl_n = 1'b1;
    endtask : pulse_abort
    task automatic pulse_err(input logic [19:0] code);
        err_code_in = code;
        err_event = 4'h4;
        cyc(1);
        err_event = 4'h0;
        cyc(1);
    endtask : pulse_err
    // Error then clear is the only way to park every channel
    task automatic stop_all();
        ext_req = 4'h0;
        err_event = 4'hf;
        cyc(1);
        err_event = 4'h0;
        err_clear = 4'hf;
        cyc(1);
        err_clear = 4'h0;
        cyc(30);
    endtask : stop_all
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk(channel_priority_reg, 8'h00);
        chk({active_reg, err_flag_reg, bus_request_n, bus_grant_acknowledge_n}, 10'h003);
    endtask : t_reset
    task automatic t_prio();
        set_prio(8'h03);
        chk(channel_priority_reg, 8'h03);
        abort_mode = 4'hf;
        ext_req = 4'h3;
        start_ch(4'h3);
        wait_for(0);
        pulse_abort();
        cyc(6);
        chk(err_flag_reg[1:0], 2'h2);
        chk(channel_error_reg[9:5], 5'h10);
        chk(active_reg[1], 1'b0);
        stop_all();
    endtask : t_prio
    task automatic t_rotate();
        set_prio(8'h00);
        ext_req = 4'h3;
        start_ch(4'h3);
        wait_for(0);
        wait_for(1);
        wait_for(2);
        wait_for(0);
        pulse_abort();
        cyc(6);
        chk(err_flag_reg[1:0], 2'h2);
        stop_all();
        abort_mode = 4'h0;
    endtask : t_rotate
    task automatic t_data();
        rd_val = 16'h3c5a;
        ext_req = 4'h4;
        start_ch(4'h4);
        wait_for(1);
        chk(data_out, 16'h3c5a);
        rr_n = 1'b0;
        wait_for(3);
        chk(bus_grant_acknowledge_n, 1'b1);
        cyc(4);
        rr_n = 1'b1;
        wait_for(1);
        chk(data_out, 16'h3c5a);
        wait_for(2);
        wait_for(1);
        rr_n = 1'b0;
        wait_for(3);
        // Host access while the write is parked; strobes and select drop together
        host_wr_data = 16'h9e1b;
        {cs_n, lds_n, uds_n} = 3'h0;
        cyc(3);
        {cs_n, lds_n, uds_n} = 3'h7;
        cyc(2);
        rr_n = 1'b1;
        wait_for(1);
        chk(data_out, 16'h9e1b);
        stop_all();
    endtask : t_data
    task automatic t_err();
        pulse_err(20'h0_0c00);
        chk(err_flag_reg[2], 1'b1);
        chk(channel_error_reg[14:10], 5'h03);
        pulse_err(20'h0_1c00);
        chk(channel_error_reg[14:10], 5'h03);
        start_ch(4'h4);
        cyc(1);
        chk(active_reg[2], 1'b0);
        chk(channel_error_reg[14:10], 5'h03);
        err_clear = 4'h4;
        cyc(1);
        err_clear = 4'h0;
        cyc(1);
        chk(err_flag_reg[2], 1'b0);
        start_ch(4'h4);
        cyc(1);
        chk(active_reg[2], 1'b1);
        stop_all();
    endtask : t_err
    task automatic t_done();
        abort_mode = 4'h1;
        dev_to_mem = 4'h1;
        ext_req = 4'h1;
        start_ch(4'h1);
        wait_for(0);
        // Done stands until the read's strobe has been taken
        done_n = 1'b0;
        wait_for(1);
        done_n = 1'b1;
        pulse_abort();
        wait_for(2);
        cyc(3);
        chk(err_flag_reg[0], 1'b0);
        chk(channel_error_reg[4:0], 5'h00);
        chk(periph_ctrl_transition_flag[0], 1'b1);
        chk(normal_termination_flag[0], 1'b1);
        stop_all();
    endtask : t_done
    task automatic t_cs();
        hold_grant = 1'b1;
        ext_req = 4'h8;
        start_ch(4'h8);
        wait_for(4);
        limited_rate = 4'h8;
        start_ch(4'h1);
        chk(bus_request_n, 1'b1);
        limited_rate = 4'h0;
        // Long word: select released one clock after the strobes, then four clocks after
        long_access = 1'b1;
        host_wr_data = 16'h5a3c;
        {cs_n, lds_n, uds_n} = 3'h0;
        cyc(2);
        {lds_n, uds_n} = 2'h3;
        cyc(1);
        cs_n = 1'b1;
        cyc(3);
        chk(lower_word_reg, 16'h5a3c);
        {cs_n, lds_n, uds_n} = 3'h0;
        cyc(2);
        {lds_n, uds_n} = 2'h3;
        cyc(3);
        chk(bus_request_n, 1'b1);
        cyc(1);
        chk(bus_request_n, 1'b1);
        cs_n = 1'b1;
        cyc(3);
        chk(lower_word_reg, 16'h0000);
        long_access = 1'b0;
        hold_grant = 1'b0;
        stop_all();
    endtask : t_cs
    initial begin
        {rst_n, pcl_n, done_n, rr_n, cs_n, lds_n, uds_n, hold_grant, slow, long_access} = 10'h1f8;
        {start, ext_req, prio_wr, err_clear, err_event, abort_mode, dev_to_mem, limited_rate} = 32'h0;
        prio_wr_data = 8'h00;
        err_code_in = 20'h0_0000;
        host_wr_data = 16'h0000;
        rd_val = 16'h0000;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        slow = 1'b1;
        cyc(1);
        t_reset();
        t_prio();
        t_rotate();
        t_data();
        t_err();
        t_done();
        t_cs();
        report_and_stop();
    end
endmodule : test_dma_channel_ctrl
